// ===== logic/bridge_gate_control_fault_blank.sv
// Gate command decode, dead interval insertion and short fault latch
// for a full H-bridge.
// Assumes all pin inputs are asynchronous to clk and that the
// analogue comparators deliver a digital level per FET.
`timescale 1ns/1ps
`default_nettype none

module bridge_gate_control_fault_blank
  import bridge_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pwm_high_input,
  input wire logic pwm_low_input,
  input wire logic direction_input,
  input wire logic sync_rect_enable,
  input wire logic short_threshold_input,
  input wire logic [7:0] dead_setting_resistor,
  input wire logic [N_FET-1:0] ds_over_threshold,
  output logic [N_PHASE-1:0] gate_high,
  output logic [N_PHASE-1:0] gate_low,
  output logic [N_FET-1:0] short_fault,
  output logic fault_flag_a_out,
  output logic fault_flag_a_oe,
  output logic fault_flag_b_out,
  output logic fault_flag_b_oe
);

  // State of the controller apart from the per-FET blank timers
  typedef struct packed {
    pin_t sync1;
    pin_t sync2;
    logic [CNT_W-1:0] dead_cyc;
    logic [N_PHASE-1:0] gate_hi;
    logic [N_PHASE-1:0] gate_lo;
    logic [N_PHASE-1:0][CNT_W-1:0] dead_cnt;
    logic [N_PHASE-1:0] after_hi;
    logic [N_PHASE-1:0] after_lo;
    logic [N_FET-1:0] fault;
    logic flag_b;
  } ctl_state_t;

  ctl_state_t st_reg;
  ctl_state_t st_next;
  pin_t pins;
  gate_cmd_t cmd;
  logic [N_FET-1:0] fet_on;
  logic [N_FET-1:0] detect;
  logic [CNT_W-1:0] blank_cyc;
  logic monitor_on;

  // Decode bridge inputs into gate commands per phase.
  // The source phase is A when direction is high, else B.
  function automatic gate_cmd_t decode(input logic h, input logic l,
                                       input logic d, input logic sr);
    gate_cmd_t c;
    int src;
    int snk;
    c = '0;
    src = d ? PH_A : PH_B;
    snk = d ? PH_B : PH_A;
    if (h && l) begin
      // Drive: source high and sink low on; toggling direction with
      // all inputs high swaps all four FETs
      c.hi[src] = 1'b1;
      c.lo[snk] = 1'b1;
    end else if (!h && l) begin
      // High-side off-time: recirculate through the lows
      c.lo[snk] = 1'b1;
      c.lo[src] = sr;
    end else if (h && !l) begin
      // Low-side off-time: recirculate through the highs
      c.hi[src] = 1'b1;
      c.hi[snk] = sr;
    end else begin
      // Both PWM low: coast with every gate low
      c = '0;
    end
    return c;
  endfunction

  // Dead interval in cycles from the resistor setting.
  // t = 50 + 7200 / (1.2 + 200 / R), reworked to integer form.
  function automatic logic [CNT_W-1:0] dead_cycles(input logic [7:0] r);
    int rk;
    int ns;
    int cyc;
    rk = int'(r);
    if (r == RES_TIED_TO_RAIL) begin
      ns = DEAD_MAX_NS;
    end else begin
      if (r < RES_MIN_KOHM) begin
        rk = int'(RES_MIN_KOHM);
      end
      if (r > RES_MAX_KOHM) begin
        rk = int'(RES_MAX_KOHM);
      end
      ns = DEAD_BASE_NS +
        (DEAD_SCALE_NS * 10 * rk) / (12 * rk + 2000);
    end
    cyc = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    if (cyc < 1) begin
      cyc = 1;
    end
    if (cyc > DEAD_MAX_CYC) begin
      cyc = DEAD_MAX_CYC;
    end
    return cyc[CNT_W-1:0];
  endfunction

  // Gather the asynchronous pins into one vector
  always_comb begin
    pins.dead_res = dead_setting_resistor;
    pins.monitor_off = short_threshold_input;
    pins.sync_rect = sync_rect_enable;
    pins.direction = direction_input;
    pins.pwm_low = pwm_low_input;
    pins.pwm_high = pwm_high_input;
    pins.ds_over = ds_over_threshold;
  end

  // Everything past the synchroniser reads the second stage only
  assign monitor_on = !st_reg.sync2.monitor_off;
  assign cmd = decode(st_reg.sync2.pwm_high, st_reg.sync2.pwm_low,
                      st_reg.sync2.direction, st_reg.sync2.sync_rect);
  // Blank is dead interval plus monitor latency
  assign blank_cyc = st_reg.dead_cyc +
    BLANK_EXTRA_CYC[CNT_W-1:0];

  // Per-FET gate state, index phase * 2 + side
  for (genvar p = 0; p < N_PHASE; p++) begin : g_fet_map
    assign fet_on[2*p] = st_reg.gate_hi[p];
    assign fet_on[2*p+1] = st_reg.gate_lo[p];
  end

  // One blank timer per FET; high-side monitors catch shorts to
  // ground, low-side monitors shorts to supply, and a shorted load
  // shows up on both without a detector of its own
  for (genvar f = 0; f < N_FET; f++) begin : g_blank
    fet_blank_timer u_blank (
      .clk(clk),
      .rst_n(rst_n),
      .gate_on(fet_on[f]),
      .blank_cyc(blank_cyc),
      .ds_over(st_reg.sync2.ds_over[f]),
      .monitor_on(monitor_on),
      .short_detect(detect[f])
    );
  end

  // Next-state logic: synchroniser, dead timing, fault latch, flags
  always_comb begin
    logic kill;
    logic want_hi;
    logic want_lo;
    logic hi_off;
    logic lo_off;
    logic hi_block;
    logic lo_block;
    kill = 1'b0;
    want_hi = 1'b0;
    want_lo = 1'b0;
    hi_off = 1'b0;
    lo_off = 1'b0;
    hi_block = 1'b0;
    lo_block = 1'b0;
    st_next = st_reg;

    // Two-stage synchroniser for every pin
    st_next.sync1 = pins;
    st_next.sync2 = st_reg.sync1;

    // Dead interval follows the setting, refreshed every cycle
    st_next.dead_cyc = dead_cycles(st_reg.sync2.dead_res);

    // Latch short faults; held until reset, set only while enabled
    st_next.fault = st_reg.fault | detect;

    // Any latched fault takes the whole bridge down
    kill = |st_reg.fault;

    for (int p = 0; p < N_PHASE; p++) begin
      want_hi = cmd.hi[p] && !kill && !st_reg.fault[2*p];
      want_lo = cmd.lo[p] && !kill && !st_reg.fault[2*p+1];
      hi_off = st_reg.gate_hi[p] && !want_hi;
      lo_off = st_reg.gate_lo[p] && !want_lo;

      // Count down the running dead interval
      if (st_reg.dead_cnt[p] != CNT_ZERO) begin
        st_next.dead_cnt[p] = st_reg.dead_cnt[p] - CNT_ONE;
      end

      // A turn-off starts the dead interval for its partner
      if (hi_off) begin
        st_next.gate_hi[p] = 1'b0;
        st_next.dead_cnt[p] = st_reg.dead_cyc - CNT_ONE;
        st_next.after_hi[p] = 1'b1;
        st_next.after_lo[p] = 1'b0;
      end
      if (lo_off) begin
        st_next.gate_lo[p] = 1'b0;
        st_next.dead_cnt[p] = st_reg.dead_cyc - CNT_ONE;
        st_next.after_lo[p] = 1'b1;
        st_next.after_hi[p] = 1'b0;
      end

      // Turn-on waits only while the partner is on or its dead
      // interval is still running; otherwise it goes straight on
      hi_block = st_reg.gate_lo[p] || (st_reg.after_lo[p] &&
        (st_reg.dead_cnt[p] != CNT_ZERO));
      lo_block = st_reg.gate_hi[p] || (st_reg.after_hi[p] &&
        (st_reg.dead_cnt[p] != CNT_ZERO));

      // Body diode carries current only inside this gap
      if (want_hi && !st_reg.gate_hi[p] && !hi_block && !want_lo) begin
        st_next.gate_hi[p] = 1'b1;
      end
      if (want_lo && !st_reg.gate_lo[p] && !lo_block && !want_hi) begin
        st_next.gate_lo[p] = 1'b1;
      end
    end

    // Short faults raise flag b only, OR over all latched faults,
    // and nothing shows while monitoring is disabled
    st_next.flag_b = (|st_next.fault) && monitor_on;
  end

  // State register with synchronous reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_reg <= '0;
      st_reg.dead_cyc <= DEAD_RESET_CYC;
    end else begin
      st_reg <= st_next;
    end
  end

  // Gate and status outputs come straight from the state register
  assign gate_high = st_reg.gate_hi;
  assign gate_low = st_reg.gate_lo;
  assign short_fault = st_reg.fault;

  // Open-drain flags: pull low when clear, release to show a fault.
  // Flag a carries only temperature faults, not handled here.
  assign fault_flag_a_out = 1'b0;
  assign fault_flag_a_oe = 1'b1;
  assign fault_flag_b_out = 1'b0;
  assign fault_flag_b_oe = !st_reg.flag_b;

endmodule // bridge_gate_control_fault_blank

`default_nettype wire

// ===== logic/bridge_pkg.sv
// Shared constants and carrier types for the bridge gate control block.
// Assumes a 10 MHz clock; fixed times become cycles here, the dead interval in the controller.
package bridge_pkg;

  // Clock period
  localparam int CLK_PERIOD_NS = 100;

  // Dead interval: base plus a resistor-dependent term
  localparam int DEAD_BASE_NS = 50;
  localparam int DEAD_SCALE_NS = 7200;
  localparam int DEAD_MAX_NS = 6000;
  // Resistor setting limits in kilo-ohms; zero means tied to the rail
  localparam logic [7:0] RES_TIED_TO_RAIL = 8'h00;
  localparam logic [7:0] RES_MIN_KOHM = 8'h03;
  localparam logic [7:0] RES_MAX_KOHM = 8'hF0;

  // Extra blanking for monitor latency; least time, rounded up
  localparam int BLANK_EXTRA_NS = 600;
  localparam int BLANK_EXTRA_CYC =
    (BLANK_EXTRA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Longest dead interval in cycles
  localparam int DEAD_MAX_CYC =
    (DEAD_MAX_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Counter width for dead and blank counters
  localparam int CNT_W = 7;

  // FET index: phase * 2 + side, side 0 high, side 1 low
  localparam int N_PHASE = 2;
  localparam int N_FET = 4;
  localparam int PH_A = 0;
  localparam int PH_B = 1;

  // Counter constants and reset values
  localparam logic [CNT_W-1:0] CNT_ZERO = 7'h00;
  localparam logic [CNT_W-1:0] CNT_ONE = 7'h01;
  localparam logic [CNT_W-1:0] DEAD_RESET_CYC = 7'h3C;

  // Pins from outside the clock domain, synchronised as one vector
  typedef struct packed {
    logic [7:0] dead_res;     // Dead setting resistor in kilo-ohms
    logic monitor_off;        // Threshold at monitor-disable level
    logic sync_rect;
    logic direction;
    logic pwm_low;
    logic pwm_high;
    logic [N_FET-1:0] ds_over; // Drain-source above threshold, per FET
  } pin_t;

  // Gate commands per phase
  typedef struct packed {
    logic [N_PHASE-1:0] hi;
    logic [N_PHASE-1:0] lo;
  } gate_cmd_t;

  // State of the per-FET blank timer
  typedef struct packed {
    logic gate_prev;
    logic [CNT_W-1:0] cnt;
  } blank_state_t;

endpackage

// ===== logic/fet_blank_timer.sv
// Fault blank timer and short detector for one external FET.
// Assumes gate_on and ds_over are already in the clk domain.
`timescale 1ns/1ps
`default_nettype none

module fet_blank_timer
  import bridge_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic gate_on,
  input wire logic [CNT_W-1:0] blank_cyc,
  input wire logic ds_over,
  input wire logic monitor_on,
  output logic short_detect
);

  blank_state_t st_reg;
  blank_state_t st_next;

  // Load blank count at turn-on, then count down while on
  always_comb begin
    st_next = st_reg;
    st_next.gate_prev = gate_on;
    if (gate_on && !st_reg.gate_prev) begin
      st_next.cnt = blank_cyc;
    end else if (!gate_on) begin
      st_next.cnt = CNT_ZERO;
    end else if (st_reg.cnt != CNT_ZERO) begin
      st_next.cnt = st_reg.cnt - CNT_ONE;
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Comparator counts only while on, past blanking, monitor enabled
  assign short_detect = gate_on && st_reg.gate_prev &&
    (st_reg.cnt == CNT_ZERO) && ds_over && monitor_on;

endmodule // fet_blank_timer

`default_nettype wire

// ===== bench/bridge_chk.sv
// Checker for the bridge gate control block, bound to its top module.
// Assumes the port names and FET order of the design's top module.
`timescale 1ns/1ps
`default_nettype none
module bridge_chk
  import bridge_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pwm_high_input,
  input wire logic pwm_low_input,
  input wire logic sync_rect_enable,
  input wire logic short_threshold_input,
  input wire logic [N_PHASE-1:0] gate_high,
  input wire logic [N_PHASE-1:0] gate_low,
  input wire logic [N_FET-1:0] short_fault,
  input wire logic fault_flag_a_out,
  input wire logic fault_flag_a_oe,
  input wire logic fault_flag_b_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [3:0] g, prev_g, prev_f, newf, long_on;
  logic [6:0] on_cnt [4];
  // Gates in FET order, newly latched faults, on-time past the least blank
  assign g = {gate_low[1], gate_high[1], gate_low[0], gate_high[0]};
  assign newf = short_fault & ~prev_f;
  always_comb begin
    for (int i = 0; i < 4; i++) long_on[i] = on_cnt[i] >= 7'h07;
  end
  // History of gates and faults, saturating on-time per FET
  always_ff @(posedge clk) begin
    prev_g <= g;
    prev_f <= short_fault;
    for (int i = 0; i < 4; i++) begin
      if (!g[i]) on_cnt[i] <= 7'h00;
      else if (on_cnt[i] != 7'h7F) on_cnt[i] <= on_cnt[i] + 7'h01;
    end
  end
  property p_no_shoot; (gate_high & gate_low) == 2'h0; endproperty
  a_no_shoot: assert property (p_no_shoot) else $error("shoot-through");
  property p_gap; $fell(gate_high[0]) |-> !gate_low[0]; endproperty
  a_gap: assert property (p_gap) else $error("no dead gap");
  property p_kill; (|short_fault) |=> g == 4'h0; endproperty
  a_kill: assert property (p_kill) else $error("gate on in fault");
  property p_hold; (prev_f & ~short_fault) == 4'h0; endproperty
  a_hold: assert property (p_hold) else $error("fault cleared");
  property p_off_ign; (newf & ~prev_g) == 4'h0; endproperty
  a_off_ign: assert property (p_off_ign) else $error("fault on off FET");
  property p_blank; (newf & ~long_on) == 4'h0; endproperty
  a_blank: assert property (p_blank) else $error("fault in blank");
  property p_mask; short_threshold_input[*6] |-> fault_flag_b_oe; endproperty
  a_mask: assert property (p_mask) else $error("flag not masked");
  property p_no_new; short_threshold_input[*6] |-> newf == 4'h0; endproperty
  a_no_new: assert property (p_no_new) else $error("fault when off");
  property p_flag_b;
    ((|short_fault) && !short_threshold_input)[*4] |-> !fault_flag_b_oe;
  endproperty
  a_flag_b: assert property (p_flag_b) else $error("flag b idle");
  property p_flag_a; fault_flag_a_oe && !fault_flag_a_out; endproperty
  a_flag_a: assert property (p_flag_a) else $error("flag a set");
  property p_coast;
    (!pwm_high_input && !pwm_low_input && !sync_rect_enable)[*5] |-> g == 4'h0;
  endproperty
  a_coast: assert property (p_coast) else $error("coast gates on");
  c_fault: cover property ($rose(|short_fault));
  c_four: cover property (gate_high[0] && gate_low[1]);
  c_brake: cover property (gate_low == 2'h3);
endmodule // bridge_chk
bind bridge_gate_control_fault_blank bridge_chk bridge_chk_inst (
  .clk(clk), .rst_n(rst_n), .pwm_high_input(pwm_high_input),
  .pwm_low_input(pwm_low_input), .sync_rect_enable(sync_rect_enable),
  .short_threshold_input(short_threshold_input), .gate_high(gate_high),
  .gate_low(gate_low), .short_fault(short_fault),
  .fault_flag_a_out(fault_flag_a_out), .fault_flag_a_oe(fault_flag_a_oe),
  .fault_flag_b_oe(fault_flag_b_oe));
`default_nettype wire

// ===== bench/fet_model.sv
// Model of the four external FETs and their drain-source comparators.
// Assumes gate_on in order A-high, A-low, B-high, B-low.
`timescale 1ns/1ps
`default_nettype none
module fet_model (
  input wire logic clk,
  input wire logic [3:0] gate_on,
  input wire logic [3:0] short_inj,
  output logic [3:0] ds_over
);
  logic tog = 1'b0;
  logic [1:0] age [4] = '{2'h0, 2'h0, 2'h0, 2'h0};
  // On-time age per FET, saturating once switching has settled
  always_ff @(posedge clk) begin
    tog <= ~tog;
    for (int i = 0; i < 4; i++) begin
      if (!gate_on[i]) age[i] <= 2'h0;
      else if (age[i] != 2'h3) age[i] <= age[i] + 2'h1;
    end
  end
  // Off FETs give a meaningless toggling level; on FETs a transient
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      ds_over[i] = gate_on[i] ? (age[i] != 2'h3 || short_inj[i]) : tog;
    end
  end
endmodule // fet_model
`default_nettype wire

// ===== bench/test_bridge_gate_control_fault_blank.sv
// Self-checking bench for the bridge gate control block.
// Assumes a 10 MHz clock and the FET model on the comparator inputs.
`timescale 1ns/1ps
`default_nettype none
module test_bridge_gate_control_fault_blank import bridge_pkg::*;;
  logic clk = 1'b0, rst_n = 1'b0;
  logic h = 1'b0, l = 1'b0, d = 1'b0, sr = 1'b0, thr = 1'b0;
  logic [7:0] res = 8'h03;
  logic [3:0] inj = 4'h0, ds, g, sf;
  logic [1:0] gh, gl;
  logic fa_out, fa_oe, fb_out, fb_oe;
  logic [15:0] rnd = 16'h639E;
  logic [3:0] fmask [5] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h9};
  logic [7:0] rtab [6] = '{8'h00, 8'h01, 8'h03, 8'h3C, 8'hF0, 8'hFF};
  int err_count = 0, comparisons = 0, cyc = 0, k;
  assign g = {gl[1], gh[1], gl[0], gh[0]};
  bridge_gate_control_fault_blank bridge_gate_control_fault_blank_inst (
    .clk(clk), .rst_n(rst_n), .pwm_high_input(h), .pwm_low_input(l),
    .direction_input(d), .sync_rect_enable(sr), .short_threshold_input(thr),
    .dead_setting_resistor(res), .ds_over_threshold(ds), .gate_high(gh),
    .gate_low(gl), .short_fault(sf), .fault_flag_a_out(fa_out),
    .fault_flag_a_oe(fa_oe), .fault_flag_b_out(fb_out), .fault_flag_b_oe(fb_oe));
  fet_model fet_model_inst (.clk(clk), .gate_on(g), .short_inj(inj),
    .ds_over(ds));
  // Clock and run limit
  always #50 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      give_verdict();
    end
  end
  // Expected gates for mode {h, l, d, sr}; source phase A when d high
  function automatic logic [3:0] exp_g(logic [3:0] m);
    logic sh, sl, kh, kl;
    sh = m[3];
    kl = m[2];
    sl = !m[3] & m[2] & m[0];
    kh = m[3] & !m[2] & m[0];
    return m[1] ? {kl, kh, sl, sh} : {sl, sh, kl, kh};
  endfunction
  // Dead interval in cycles for a resistor code
  function automatic int dead_of(logic [7:0] r);
    int rr;
    rr = (r < 8'h03) ? 3 : (r > 8'hF0) ? 240 : int'(r);
    if (r == 8'h00) return 60;
    rr = (73800 * rr + 299999) / (1200 * rr + 200000);
    return (rr > 60) ? 60 : rr;
  endfunction
  function automatic logic [15:0] lfsr(logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk(string name, logic [7:0] seen, logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic set_mode(logic [3:0] m);
    @(posedge clk);
    {h, l, d, sr} <= m;
  endtask
  // Edges until a gate in msk is on
  task automatic wait_g(logic [3:0] msk, output int n);
    n = 0;
    #1;
    while ((|(g & msk)) !== 1'b1 && n < 200) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask
  task automatic do_reset();
    @(posedge clk);
    rst_n <= 1'b0;
    {h, l, d, sr, thr, inj, res} <= 17'h00003;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
  endtask
  task automatic give_verdict();
    if (err_count == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Main sequence
  initial begin
    do_reset();
    #1;
    chk("reset", {fb_oe, fa_oe, fa_out, fb_out, g}, 8'hC0);
    for (int m = 0; m < 16; m++) begin
      set_mode(4'(m));
      repeat (80) @(posedge clk);
      #1;
      chk("decode", g, exp_g(4'(m)));
    end
    chk("false fault", sf, 4'h0);
    repeat (24) begin
      rnd = lfsr(rnd);
      set_mode(rnd[11:8]);
      res <= rnd[7:0];
      repeat (80) @(posedge clk);
      #1;
      chk("random", g, exp_g(rnd[11:8]));
    end
    set_mode(4'h0);
    repeat (80) @(posedge clk);
    set_mode(4'hE);
    wait_g(4'h1, k);
    chk("latency", 8'(k), 8'h03);
    foreach (rtab[j]) begin
      set_mode(4'hF);
      res <= rtab[j];
      repeat (80) @(posedge clk);
      set_mode(4'hD);
      wait_g(4'h2, k);
      chk("dead", 8'(k), 8'(3 + dead_of(rtab[j])));
    end
    foreach (fmask[j]) begin
      do_reset();
      inj <= fmask[j];
      set_mode({2'b11, fmask[j][0] | fmask[j][3], 1'b0});
      wait_g(fmask[j], k);
      repeat (7) @(posedge clk);
      #1;
      chk("blanked", sf, 4'h0);
      k = 0;
      while (sf === 4'h0 && k < 20) begin
        @(posedge clk);
        #1;
        k++;
      end
      chk("fault", sf, fmask[j]);
      repeat (2) @(posedge clk);
      #1;
      chk("kill", {fb_oe, g}, 8'h00);
      @(posedge clk);
      inj <= 4'h0;
      thr <= 1'b1;
      repeat (20) @(posedge clk);
      #1;
      chk("held", {fb_oe, sf}, {4'h1, fmask[j]});
    end
    do_reset();
    @(posedge clk);
    thr <= 1'b1;
    inj <= 4'hF;
    set_mode(4'hE);
    repeat (60) @(posedge clk);
    #1;
    chk("disabled", {fb_oe, sf}, 8'h10);
    give_verdict();
  end
endmodule // test_bridge_gate_control_fault_blank
`default_nettype wire
